/* File: common/obcd_params.svh */
// constants for the option byte configuration decoder
`ifndef OBCD_PARAMS_SVH
`define OBCD_PARAMS_SVH
// shipped and erased byte values
`define OBCD_BYTE0_DEFAULT 8'hfc
`define OBCD_BYTE1_DEFAULT 8'hef
`define OBCD_ERASED 8'hff
// byte selector codes
`define OBCD_SEL_BYTE0 1'b0
`define OBCD_SEL_BYTE1 1'b1
// byte 0 field positions
`define OBCD_B0_HALT_RST 7
`define OBCD_B0_WATCHDOG_SOFTWARE_SELECT 6
`define OBCD_B0_VD_HI 5
`define OBCD_B0_VD_LO 4
`define OBCD_B0_SEC_HI 3
`define OBCD_B0_SEC_LO 2
`define OBCD_B0_RDP 1
`define OBCD_B0_WRP 0
// byte 1 field positions
`define OBCD_B1_IRQ_MAP 7
`define OBCD_B1_RSVD 6
`define OBCD_B1_CLK_HI 5
`define OBCD_B1_CLK_LO 4
`define OBCD_B1_BAND_TOP 3
`define OBCD_B1_BAND_HI 2
`define OBCD_B1_BAND_LO 1
`define OBCD_B1_PLL_OFF 0
`endif

/* File: common/obcd_pkg.sv */
// types shared by the option byte configuration decoder
package obcd_pkg;
   // programming command codes, 2'h3 is illegal
   typedef enum logic [1:0] {
      OBCD_CMD_READ = 2'h0,
      OBCD_CMD_WRITE = 2'h1,
      OBCD_CMD_ERASE = 2'h2
   } obcd_cmd_t;
   // sequencer states, gray along idle, mass, opt
   typedef enum logic [1:0] {
      OBCD_ST_IDLE = 2'h0,
      OBCD_ST_MASS = 2'h1,
      OBCD_ST_OPT = 2'h3
   } obcd_state_t;
   // voltage detector threshold codes as stored
   typedef enum logic [1:0] {
      OBCD_VD_HIGHEST = 2'h0,
      OBCD_VD_MEDIUM = 2'h1,
      OBCD_VD_LOWEST = 2'h2,
      OBCD_VD_OFF = 2'h3
   } obcd_vd_t;
   // first sector size codes
   typedef enum logic [1:0] {
      OBCD_SEC_0K5 = 2'h0,
      OBCD_SEC_1K = 2'h1,
      OBCD_SEC_2K = 2'h2,
      OBCD_SEC_4K = 2'h3
   } obcd_sector_t;
   // clock source kinds
   typedef enum logic [1:0] {
      OBCD_CLK_RESONATOR = 2'h0,
      OBCD_CLK_RESERVED = 2'h1,
      OBCD_CLK_INTERNAL_RC = 2'h2,
      OBCD_CLK_EXTERNAL = 2'h3
   } obcd_clk_src_t;
   // oscillator band, decoded
   typedef enum logic [2:0] {
      OBCD_BAND_VERY_LOW_POWER = 3'h0,
      OBCD_BAND_LOW_POWER = 3'h1,
      OBCD_BAND_MEDIUM_POWER = 3'h2,
      OBCD_BAND_MEDIUM_SPEED = 3'h3,
      OBCD_BAND_HIGH_SPEED = 3'h4
   } obcd_band_t;
   // one programming request
   typedef struct packed {
      obcd_cmd_t cmd;
      logic sel;
      logic [7:0] wdata;
   } obcd_prog_req_t;
   // one programming answer
   typedef struct packed {
      logic done;
      logic refused;
      logic [7:0] rdata;
   } obcd_prog_rsp_t;
   // settings decoded from byte 0
   typedef struct packed {
      logic halt_entry_watchdog_reset;
      logic watchdog_software_select;
      logic low_voltage_detector;
      logic auxiliary_voltage_detector;
      obcd_vd_t voltage_detect_threshold_sel;
      obcd_sector_t first_sector_size_sel;
      logic readout_protect_bit;
      logic write_protect_bit;
   } obcd_core_cfg_t;
   // settings decoded from byte 1
   typedef struct packed {
      logic port_c_irq_mapping;
      obcd_clk_src_t clock_source_kind;
      logic clock_source_reserved;
      obcd_band_t oscillator_band_sel;
      logic pll_double_enable;
      logic pll_config_unsafe;
   } obcd_clk_cfg_t;
   // whole state of the top module
   typedef struct packed {
      obcd_state_t phase;
      obcd_prog_rsp_t rsp;
      logic mass_erase;
      logic loaded;
      obcd_core_cfg_t core;
      obcd_clk_cfg_t clk;
      logic read_block;
      logic write_block;
      logic halt_reset;
   } obcd_dec_state_t;
   // state of one stored byte
   typedef struct packed {
      logic [7:0] value;
   } obcd_nv_state_t;
endpackage

/* File: rtl/obcd_clock_decode.sv */
// decoder for the clock and interrupt option byte
`timescale 1ns/1ps
`include "obcd_params.svh"
module obcd_clock_decode import obcd_pkg::*; (
   // raw byte
   input wire logic [7:0] opt_byte,
   // decoded settings
   output obcd_clk_cfg_t cfg
);
   // pure decode, registered by the caller
   always_comb begin
      cfg = '0;
      // port c lines go with port b on vector b when set
      cfg.port_c_irq_mapping = opt_byte[`OBCD_B1_IRQ_MAP];
      cfg.clock_source_kind = obcd_clk_src_t'(
         opt_byte[`OBCD_B1_CLK_HI:`OBCD_B1_CLK_LO]);
      cfg.clock_source_reserved =
         (cfg.clock_source_kind == OBCD_CLK_RESERVED);
      // top bit set picks the slow band, low bits ignored
      if (opt_byte[`OBCD_B1_BAND_TOP]) begin
         cfg.oscillator_band_sel = OBCD_BAND_VERY_LOW_POWER;
      end else begin
         unique case (opt_byte[`OBCD_B1_BAND_HI:`OBCD_B1_BAND_LO])
            2'h0: cfg.oscillator_band_sel = OBCD_BAND_LOW_POWER;
            2'h1: cfg.oscillator_band_sel = OBCD_BAND_MEDIUM_POWER;
            2'h2: cfg.oscillator_band_sel = OBCD_BAND_MEDIUM_SPEED;
            2'h3: cfg.oscillator_band_sel = OBCD_BAND_HIGH_SPEED;
         endcase
      end
      // doubler is active low in the byte
      cfg.pll_double_enable = !opt_byte[`OBCD_B1_PLL_OFF];
      // flag only: doubling outside its guaranteed pairing
      cfg.pll_config_unsafe = cfg.pll_double_enable &&
         ((cfg.clock_source_kind == OBCD_CLK_INTERNAL_RC) ||
          (cfg.oscillator_band_sel != OBCD_BAND_MEDIUM_POWER));
   end
endmodule

/* File: rtl/obcd_nv_byte.sv */
// one non-volatile option byte cell
`timescale 1ns/1ps
module obcd_nv_byte import obcd_pkg::*; #(
   parameter logic [7:0] DEFAULT_VALUE = 8'hff,
   parameter bit HARD_WIRED = 1'b0,
   parameter logic [7:0] WIRED_VALUE = 8'hff
) (
   // clock and power-on reset
   input wire logic clk,
   input wire logic por_n,
   // store port
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   // stored value
   output logic [7:0] value
);
   obcd_nv_state_t r; // held byte
   obcd_nv_state_t next_r; // next byte

   // store on request; a hard-wired byte ignores writes
   always_comb begin
      next_r = r;
      if (wr_en && !HARD_WIRED) begin
         next_r.value = wr_data;
      end
   end

   // only power-on reloads the cell with its default, not device reset
   always_ff @(posedge clk or negedge por_n) begin
      if (!por_n) begin
         r <= HARD_WIRED ? WIRED_VALUE : DEFAULT_VALUE;
      end else begin
         r <= next_r;
      end
   end

   assign value = HARD_WIRED ? WIRED_VALUE : r.value;
endmodule

/* File: rtl/obcd_option_decoder.sv */
// option byte store, programming port and configuration decoder
`timescale 1ns/1ps
`include "obcd_params.svh"
module obcd_option_decoder import obcd_pkg::*; #(
   // part is factory programmed, allows the 4k sector
   parameter bit FACTORY_PROGRAMMED = 1'b0,
   // part is mask programmed, bytes are wired
   parameter bit MASK_PROGRAMMED = 1'b0,
   // wired byte values for a mask part
   parameter logic [7:0] MASK_BYTE0 = 8'hff,
   parameter logic [7:0] MASK_BYTE1 = 8'hff
) (
   // clock and resets
   input wire logic clk,
   input wire logic reset_n,
   input wire logic por_n,
   // programming port
   input wire logic prog_mode,
   input wire logic prog_valid,
   input wire obcd_prog_req_t prog_req,
   output obcd_prog_rsp_t prog_rsp,
   // program memory erase request
   output logic flash_mass_erase,
   // watchdog and halt status
   input wire logic halt_entry,
   input wire logic watchdog_active,
   output logic halt_reset_req,
   // decoded configuration
   output logic cfg_valid,
   output obcd_core_cfg_t core_cfg,
   output obcd_clk_cfg_t clk_cfg,
   // flash protection status
   output logic flash_read_block,
   output logic flash_write_block
);

   // ****************************************
   // storage
   // ****************************************

   logic [7:0] byte0; // live protection and watchdog byte
   logic [7:0] byte1; // live clock and interrupt byte
   logic wr_en0; // store strobe for byte 0
   logic wr_en1; // store strobe for byte 1
   logic [7:0] wr_data; // value to store

   // protection and watchdog byte
   obcd_nv_byte #(
      .DEFAULT_VALUE(`OBCD_BYTE0_DEFAULT),
      .HARD_WIRED(MASK_PROGRAMMED),
      .WIRED_VALUE(MASK_BYTE0)
   ) u_byte0 (
      .clk(clk),
      .por_n(por_n),
      .wr_en(wr_en0),
      .wr_data(wr_data),
      .value(byte0)
   );

   // clock and interrupt byte
   obcd_nv_byte #(
      .DEFAULT_VALUE(`OBCD_BYTE1_DEFAULT),
      .HARD_WIRED(MASK_PROGRAMMED),
      .WIRED_VALUE(MASK_BYTE1)
   ) u_byte1 (
      .clk(clk),
      .por_n(por_n),
      .wr_en(wr_en1),
      .wr_data(wr_data),
      .value(byte1)
   );

   // ****************************************
   // decode of the live bytes
   // ****************************************

   obcd_clk_cfg_t live_clk; // byte 1 decoded
   obcd_core_cfg_t live_core; // byte 0 decoded

   // byte 1 has its own decoder
   obcd_clock_decode u_clock_decode (
      .opt_byte(byte1),
      .cfg(live_clk)
   );

   // byte 0 decode
   always_comb begin
      live_core = '0;
      // halt reset request enable
      live_core.halt_entry_watchdog_reset =
         byte0[`OBCD_B0_HALT_RST];
      // zero means the watchdog runs from reset
      live_core.watchdog_software_select =
         byte0[`OBCD_B0_WATCHDOG_SOFTWARE_SELECT];
      live_core.voltage_detect_threshold_sel = obcd_vd_t'(
         byte0[`OBCD_B0_VD_HI:`OBCD_B0_VD_LO]);
      // both detectors share one enable
      live_core.low_voltage_detector =
         (live_core.voltage_detect_threshold_sel != OBCD_VD_OFF);
      live_core.auxiliary_voltage_detector =
         live_core.low_voltage_detector;
      live_core.first_sector_size_sel = obcd_sector_t'(
         byte0[`OBCD_B0_SEC_HI:`OBCD_B0_SEC_LO]);
      // largest size falls back to 2k on other parts
      if (!FACTORY_PROGRAMMED &&
          live_core.first_sector_size_sel == OBCD_SEC_4K) begin
         live_core.first_sector_size_sel = OBCD_SEC_2K;
      end
      live_core.readout_protect_bit = byte0[`OBCD_B0_RDP];
      live_core.write_protect_bit = byte0[`OBCD_B0_WRP];
   end

   // ****************************************
   // sequencer and capture
   // ****************************************

   obcd_dec_state_t r; // registered state
   obcd_dec_state_t next_r; // next state
   logic locked; // lock from live byte until power-on; always on a mask part
   logic protected_rd; // live readout protection
   logic refuse; // request cannot be served

   // refusal reasons for the current request
   always_comb begin
      locked = byte0[`OBCD_B0_WRP] || MASK_PROGRAMMED;
      protected_rd = byte0[`OBCD_B0_RDP];
      refuse = 1'b0;
      // outside programming mode the bytes do not exist
      if (!prog_mode) begin
         refuse = 1'b1;
      end
      // a second request during an erase is turned away
      if (r.phase != OBCD_ST_IDLE) begin
         refuse = 1'b1;
      end
      unique case (prog_req.cmd)
         OBCD_CMD_READ: begin
            // reading the bytes is allowed under any protection
         end
         OBCD_CMD_WRITE: begin
            // write only through an erase when protected
            if (locked || protected_rd) begin
               refuse = 1'b1;
            end
         end
         OBCD_CMD_ERASE: begin
            // a locked part cannot be erased; only power-on clears the byte lock
            if (locked) begin
               refuse = 1'b1;
            end
         end
         default: begin
            // illegal command code
            refuse = 1'b1;
         end
      endcase
   end

   // next state, answers and store strobes
   always_comb begin
      next_r = r;
      wr_en0 = 1'b0;
      wr_en1 = 1'b0;
      wr_data = prog_req.wdata;
      // answers and the erase strobe are one-cycle pulses
      next_r.rsp.done = 1'b0;
      next_r.rsp.refused = 1'b0;
      next_r.mass_erase = 1'b0;
      unique case (r.phase)
         OBCD_ST_IDLE: begin
            if (prog_valid && refuse) begin
               next_r.rsp.done = 1'b1;
               next_r.rsp.refused = 1'b1;
               next_r.rsp.rdata = `OBCD_ERASED;
            end else if (prog_valid) begin
               unique case (prog_req.cmd)
                  OBCD_CMD_READ: begin
                     next_r.rsp.done = 1'b1;
                     next_r.rsp.rdata =
                        (prog_req.sel == `OBCD_SEL_BYTE1) ? byte1 : byte0;
                  end
                  OBCD_CMD_WRITE: begin
                     wr_en0 = (prog_req.sel == `OBCD_SEL_BYTE0);
                     wr_en1 = (prog_req.sel == `OBCD_SEL_BYTE1);
                     next_r.rsp.done = 1'b1;
                     next_r.rsp.rdata = prog_req.wdata;
                  end
                  OBCD_CMD_ERASE: begin
                     if (protected_rd) begin
                        // wipe program memory before the bytes
                        next_r.mass_erase = 1'b1;
                        next_r.phase = OBCD_ST_MASS;
                     end else begin
                        wr_data = `OBCD_ERASED;
                        wr_en0 = 1'b1;
                        wr_en1 = 1'b1;
                        next_r.rsp.done = 1'b1;
                        next_r.rsp.rdata = `OBCD_ERASED;
                     end
                  end
                  default: begin
                     // excluded by refuse
                  end
               endcase
            end
         end
         OBCD_ST_MASS: begin
            // memory wipe issued, bytes go next
            next_r.phase = OBCD_ST_OPT;
         end
         OBCD_ST_OPT: begin
            // bytes erased to all ones, which sets the write lock bit
            wr_data = `OBCD_ERASED;
            wr_en0 = 1'b1;
            wr_en1 = 1'b1;
            next_r.rsp.done = 1'b1;
            next_r.rsp.rdata = `OBCD_ERASED;
            next_r.phase = OBCD_ST_IDLE;
         end
         default: begin
            // unused code, return to idle
            next_r.phase = OBCD_ST_IDLE;
         end
      endcase
      // capture once after reset, then hold; a later
      // programming change only takes effect at reset
      if (!r.loaded) begin
         next_r.loaded = 1'b1;
         next_r.core = live_core;
         next_r.clk = live_clk;
         next_r.read_block = live_core.readout_protect_bit;
         next_r.write_block = live_core.readout_protect_bit ||
            live_core.write_protect_bit || MASK_PROGRAMMED;
      end
      // halt entry with an active watchdog requests reset if byte 0 enables it
      next_r.halt_reset = r.loaded && halt_entry && watchdog_active &&
         r.core.halt_entry_watchdog_reset;
   end

   // state register; settings read as zero until loaded
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************
   // outputs, all straight from r
   // ****************************************

   assign prog_rsp = r.rsp;
   assign flash_mass_erase = r.mass_erase;
   assign halt_reset_req = r.halt_reset;
   assign cfg_valid = r.loaded;
   assign core_cfg = r.core;
   assign clk_cfg = r.clk;
   assign flash_read_block = r.read_block;
   assign flash_write_block = r.write_block;
endmodule

/* File: sim/obcd_option_decoder_chk.sv */
// port assertions for the option byte decoder
`timescale 1ns/1ps
module obcd_option_decoder_chk import obcd_pkg::*; #(
   parameter bit FACTORY_PROGRAMMED = 1'b0,
   parameter bit MASK_PROGRAMMED = 1'b0
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // programming port
   input wire logic prog_mode,
   input wire logic prog_valid,
   input wire obcd_prog_req_t prog_req,
   input wire obcd_prog_rsp_t prog_rsp,
   input wire logic flash_mass_erase,
   // halt
   input wire logic halt_entry,
   input wire logic watchdog_active,
   input wire logic halt_reset_req,
   // decoded settings
   input wire logic cfg_valid,
   input wire obcd_core_cfg_t core_cfg,
   input wire obcd_clk_cfg_t clk_cfg,
   input wire logic flash_write_block
);
   // ******
   // checks
   // ******
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // erase answer lands two cycles after the memory wipe pulse
   sequence erase_tail;
      ##2 prog_rsp.done && !prog_rsp.refused && prog_rsp.rdata == 8'hff;
   endsequence
   // halt entry while the watchdog runs and the option asks for it
   sequence halt_cause;
      halt_entry && watchdog_active && cfg_valid && core_cfg.halt_entry_watchdog_reset;
   endsequence
   chk_refuse_flag: assert property (prog_rsp.refused |-> prog_rsp.done)
      else $error("refusal without done");
   chk_mode_gate: assert property (prog_valid && !prog_mode |=> prog_rsp.done && prog_rsp.refused)
      else $error("request outside programming mode accepted");
   chk_write_echo: assert property (prog_valid && prog_mode && prog_req.cmd == OBCD_CMD_WRITE
      |=> prog_rsp.done && prog_rsp.rdata == (prog_rsp.refused ? 8'hff : $past(prog_req.wdata)))
      else $error("write answer wrong");
   chk_mass_erase: assert property (flash_mass_erase |-> erase_tail)
      else $error("erase answer not three cycles after request");
   chk_halt_fire: assert property (halt_cause |=> halt_reset_req)
      else $error("halt reset missing");
   chk_halt_cause: assert property (halt_reset_req |-> $past(halt_entry) && $past(watchdog_active)
      && core_cfg.halt_entry_watchdog_reset)
      else $error("halt reset without cause");
   chk_cfg_hold: assert property (cfg_valid && $past(cfg_valid) |-> $stable(core_cfg)
      && $stable(clk_cfg))
      else $error("settings changed between resets");
   chk_vd_detect: assert property (cfg_valid |-> core_cfg.low_voltage_detector
      == (core_cfg.voltage_detect_threshold_sel != OBCD_VD_OFF)
      && core_cfg.auxiliary_voltage_detector == core_cfg.low_voltage_detector)
      else $error("voltage detector enable wrong");
   chk_write_block: assert property (cfg_valid |-> flash_write_block == (MASK_PROGRAMMED
      || core_cfg.readout_protect_bit || core_cfg.write_protect_bit))
      else $error("flash write block wrong");
   chk_sector_cap: assert property (cfg_valid && !FACTORY_PROGRAMMED
      |-> core_cfg.first_sector_size_sel != OBCD_SEC_4K)
      else $error("4k sector on a non-factory part");
endmodule
bind obcd_option_decoder obcd_option_decoder_chk #(.FACTORY_PROGRAMMED(FACTORY_PROGRAMMED),
   .MASK_PROGRAMMED(MASK_PROGRAMMED)) i_chk (.clk(clk), .reset_n(reset_n),
   .prog_mode(prog_mode), .prog_valid(prog_valid), .prog_req(prog_req), .prog_rsp(prog_rsp),
   .flash_mass_erase(flash_mass_erase), .halt_entry(halt_entry),
   .watchdog_active(watchdog_active), .halt_reset_req(halt_reset_req), .cfg_valid(cfg_valid),
   .core_cfg(core_cfg), .clk_cfg(clk_cfg), .flash_write_block(flash_write_block));

/* File: sim/obcd_option_decoder_tb.sv */
// self-checking bench for the option byte decoder
`timescale 1ns/1ps
module obcd_option_decoder_tb import obcd_pkg::*; ();
   // *******
   // signals
   // *******
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic por_n = 1'b0;
   logic halt_entry = 1'b0;
   logic watchdog_active = 1'b0;
   logic prog_mode, prog_valid, cfg_valid, halt_reset_req, flash_mass_erase;
   logic flash_read_block, flash_write_block;
   obcd_prog_req_t prog_req;
   obcd_prog_rsp_t prog_rsp, rsp;
   obcd_core_cfg_t core_cfg;
   obcd_clk_cfg_t clk_cfg;
   int failures = 0;
   int n_tests = 0;
   int n_mass = 0; // memory wipe pulses seen
   bit ok;
   always #2.5 clk = ~clk;
   // count memory wipe pulses
   always @(posedge clk) if (flash_mass_erase === 1'b1) n_mass++;
   obcd_option_decoder i_dut (.clk(clk), .reset_n(reset_n), .por_n(por_n), .prog_mode(prog_mode),
      .prog_valid(prog_valid), .prog_req(prog_req), .prog_rsp(prog_rsp),
      .flash_mass_erase(flash_mass_erase), .halt_entry(halt_entry),
      .watchdog_active(watchdog_active), .halt_reset_req(halt_reset_req), .cfg_valid(cfg_valid),
      .core_cfg(core_cfg), .clk_cfg(clk_cfg), .flash_read_block(flash_read_block),
      .flash_write_block(flash_write_block));
   obcd_prog_tool i_tool (.clk(clk), .prog_mode(prog_mode), .prog_valid(prog_valid),
      .prog_req(prog_req), .prog_rsp(prog_rsp));
   // *******
   // helpers
   // *******
   // expected byte 0 settings; a non-factory part turns the 4k code into 2k
   function automatic logic [9:0] exp_core(input logic [7:0] b);
      logic [1:0] sec;
      sec = (b[3:2] == 2'h3) ? 2'h2 : b[3:2];
      return {b[7], b[6], {2{b[5:4] != 2'h3}}, b[5:4], sec, b[1], b[0]};
   endfunction
   // expected byte 1 settings; unsafe flags doubling off rc or outside 2-4MHz
   function automatic logic [8:0] exp_clk(input logic [7:0] b);
      logic [2:0] band;
      band = b[3] ? 3'h0 : {1'b0, b[2:1]} + 3'h1;
      return {b[7], b[5:4], b[5:4] == 2'h1, band, ~b[0],
         ~b[0] & ((b[5:4] == 2'h2) | (b[3:1] != 3'h1))};
   endfunction
   task automatic chk_val(input string what, input logic [9:0] exp, input logic [9:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // closing report and verdict
   task automatic results();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one request judged on refusal and returned byte; a lost answer ends the run
   task automatic req(input obcd_cmd_t cmd, input logic sel, input logic [7:0] d,
         input logic refused, input logic [7:0] rdata);
      i_tool.request(cmd, sel, d, rsp, ok);
      if (!ok) begin
         failures++;
         results();
      end else begin
         chk_val("refused", {9'h0, refused}, {9'h0, rsp.refused});
         chk_val("rdata", {2'h0, rdata}, {2'h0, rsp.rdata});
      end
   endtask
   // device reset, with power-on reset when asked
   task automatic rst(input logic por, input int cycles);
      @(negedge clk);
      reset_n = 1'b0;
      por_n = ~por;
      repeat (cycles) @(negedge clk);
      reset_n = 1'b1;
      por_n = 1'b1;
      @(negedge clk);
   endtask
   task automatic chk_cfg(input logic [7:0] b0, input logic [7:0] b1);
      chk_val("cfg_valid", 10'h1, {9'h0, cfg_valid});
      chk_val("core_cfg", exp_core(b0), core_cfg);
      chk_val("clk_cfg", {1'b0, exp_clk(b1)}, {1'b0, clk_cfg});
      chk_val("read_block", {9'h0, b0[1]}, {9'h0, flash_read_block});
      chk_val("write_block", {9'h0, b0[1] | b0[0]}, {9'h0, flash_write_block});
   endtask
   // *********
   // scenarios
   // *********
   // one halt entry, watchdog running or not
   task automatic t_halt(input logic wdg, input logic exp);
      halt_entry = 1'b1;
      watchdog_active = wdg;
      // the reset request stands for the one cycle after the halt sample
      @(negedge clk);
      chk_val("halt_reset_req", {9'h0, exp}, {9'h0, halt_reset_req});
      halt_entry = 1'b0;
      watchdog_active = 1'b0;
      @(negedge clk);
   endtask
   // shipped bytes, then refusals outside programming mode and of the illegal code
   task automatic t_access();
      chk_cfg(8'hfc, 8'hef);
      req(OBCD_CMD_WRITE, 1'b0, 8'h00, 1'b1, 8'hff);
      i_tool.set_mode(1'b1);
      req(obcd_cmd_t'(2'h3), 1'b0, 8'h00, 1'b1, 8'hff);
      req(OBCD_CMD_READ, 1'b0, 8'h00, 1'b0, 8'hfc);
   endtask
   // every two-bit field code, all bands but the slow one; settings move only at the next reset
   task automatic t_table();
      logic [7:0] b0 [4] = '{8'h00, 8'h94, 8'h68, 8'hfc};
      logic [7:0] b1 [4] = '{8'h42, 8'hd1, 8'h65, 8'hf7};
      for (int i = 0; i < 4; i++) begin
         req(OBCD_CMD_WRITE, 1'b0, b0[i], 1'b0, b0[i]);
         req(OBCD_CMD_WRITE, 1'b1, b1[i], 1'b0, b1[i]);
         req(OBCD_CMD_READ, 1'b1, 8'h00, 1'b0, b1[i]);
         chk_cfg(i > 0 ? b0[i - 1] : 8'hfc, i > 0 ? b1[i - 1] : 8'hef);
         rst(1'b0, 2);
         chk_cfg(b0[i], b1[i]);
         t_halt(1'b0, 1'b0);
         t_halt(1'b1, b0[i][7]);
      end
   endtask
   // read-out protection, protected erase, then the write lock until power-on
   task automatic t_protect();
      req(OBCD_CMD_WRITE, 1'b0, 8'hfe, 1'b0, 8'hfe);
      req(OBCD_CMD_WRITE, 1'b0, 8'hfc, 1'b1, 8'hff);
      rst(1'b0, 2);
      chk_cfg(8'hfe, 8'hf7);
      req(OBCD_CMD_ERASE, 1'b0, 8'h00, 1'b0, 8'hff);
      chk_val("mass_erase", 10'h1, n_mass[9:0]);
      req(OBCD_CMD_READ, 1'b1, 8'h00, 1'b0, 8'hff);
      rst(1'b0, 2);
      chk_cfg(8'hff, 8'hff);
      req(OBCD_CMD_WRITE, 1'b0, 8'h00, 1'b1, 8'hff);
      req(OBCD_CMD_ERASE, 1'b0, 8'h00, 1'b1, 8'hff);
      chk_val("mass_erase", 10'h1, n_mass[9:0]);
      rst(1'b1, 2);
      chk_cfg(8'hfc, 8'hef);
   endtask
   // main sequence
   initial begin
      rst(1'b1, 12);
      t_access();
      t_table();
      t_protect();
      results();
   end
endmodule

/* File: sim/obcd_prog_tool.sv */
// programming tool model for the option byte port
`timescale 1ns/1ps
module obcd_prog_tool import obcd_pkg::*; (
   // clock
   input wire logic clk,
   // request side
   output logic prog_mode,
   output logic prog_valid,
   output obcd_prog_req_t prog_req,
   // answer side
   input wire obcd_prog_rsp_t prog_rsp
);
   // ***********
   // sequencing
   // ***********
   // idle until the bench asks for a request or programming mode
   initial begin
      prog_mode = 1'b0;
      prog_valid = 1'b0;
      prog_req = '0;
   end
   // one pulsed request; the answer is awaited for at most 9 cycles
   task automatic request(input obcd_cmd_t cmd, input logic sel, input logic [7:0] wdata,
         output obcd_prog_rsp_t rsp, output bit ok);
      logic [7:0] d;
      d = wdata;
      // clock byte: a careless image is patched, not sent as it is
      if (sel) begin
         d[6] = 1'b1;
         if (!d[0] && (d[5:4] == 2'h2 || d[3:1] != 3'h1)) d[0] = 1'b1;
      end
      ok = 1'b0;
      @(negedge clk);
      prog_valid = 1'b1;
      prog_req = '{cmd: cmd, sel: sel, wdata: d};
      @(negedge clk);
      // a quick answer stands only in this cycle, so look before releasing
      ok = (prog_rsp.done === 1'b1);
      rsp = prog_rsp;
      prog_valid = 1'b0;
      prog_req = ~prog_req; // released lines must not keep the last value
      for (int i = 0; i < 8 && !ok; i++) begin
         @(negedge clk);
         ok = (prog_rsp.done === 1'b1);
         rsp = prog_rsp;
      end
   endtask
   // enter or leave programming mode; only this model drives the level
   task automatic set_mode(input logic m);
      prog_mode = m;
   endtask
endmodule
